// File: dv/pll_counter_program_port_tb_top.sv
// Self-checking bench for the synthesizer counter program port.
`timescale 1ns/1ns
`include "pll_params.svh"
module pll_counter_program_port_tb_top;
  logic mclk = 1'b0, sys_rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [3:0] wstrb = 4'hf, direct_ref = 4'h0, direct_swallow = 4'h0;
  logic serial_sel = 1'b0, direct_sel = 1'b0, parallel_bank_select = 1'b0, serial_bank_select = 1'b0;
  logic ext_feature_en_n = 1'b0, reference_input = 1'b0, vco_input = 1'b0;
  wire logic [7:0] par_data;
  wire logic serial_clk, serial_data, enh_write_strobe, serial_load_strobe, bank_transfer_strobe;
  wire logic high_nibble_write_strobe, main_low_write_strobe, swallow_write_strobe, awready, wready;
  wire logic [31:0] rdata;
  wire logic [1:0] bresp, rresp;
  wire logic bvalid, arready, rvalid, phase_pulse_lower_n, phase_pulse_raise_n, lock_filter_node, diag_out;
  wire logic lock_indicator_out, lock_indicator_oe, main_divider_monitor, reference_divider_monitor;
  // Comparator, lock and monitor pins gathered into one word.
  wire logic [31:0] pfd_word = {24'h0, phase_pulse_raise_n, phase_pulse_lower_n, lock_filter_node, lock_indicator_oe,
                                lock_indicator_out, diag_out, main_divider_monitor, reference_divider_monitor};
  int err_total = 0, cmp_count = 0, cyc = 0;
  pll_counter_program_port pll_counter_program_port_inst (.*);
  pll_ctrl_model pll_ctrl_model_inst (.*);
  // Clock and hang guard.
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  task summarize;
    $display("Comparisons %0d, errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  // Bus read; data and response are compared at the answer.
  task rd(input logic [31:0] a, e, input logic [1:0] r = `RESP_OKAY);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, r});
  endtask
  task wr(input logic [31:0] a, d, input logic [1:0] e);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge mclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge mclk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    do @(posedge mclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, e});
  endtask
  task mode(input logic s, d);
    serial_sel <= s;
    direct_sel <= d;
    repeat (8) @(posedge mclk);
  endtask
  task t_par;
    mode(1'b0, 1'b0);
    pll_ctrl_model_inst.par(0, 8'ha5);
    pll_ctrl_model_inst.par(1, 8'hc3);
    pll_ctrl_model_inst.par(2, 8'h06);
    rd(`ADDR_PRIMARY, 32'hd0da5);
    rd(`ADDR_SECONDARY, 32'h0);
    pll_ctrl_model_inst.pulse(5);
    rd(`ADDR_SECONDARY, 32'hd0da5);
    pll_ctrl_model_inst.par(0, 8'h5a);
    parallel_bank_select <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(`ADDR_ACTIVE, 32'hd0d5a);
    parallel_bank_select <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(`ADDR_ACTIVE, 32'hd0da5);
    pll_ctrl_model_inst.par(3, 8'h81);
    rd(`ADDR_ENH, 32'h81);
  endtask
  task t_ser;
    mode(1'b1, 1'b0);
    pll_ctrl_model_inst.shift(20'h5c3a7, 20, 1'b0);
    pll_ctrl_model_inst.par(0, 8'hff);
    rd(`ADDR_PRIMARY, 32'h5c3a7);
    pll_ctrl_model_inst.shift(20'h0004e, 8, 1'b1);
    rd(`ADDR_ENH, 32'h4e);
    rd(`ADDR_PRIMARY, 32'h5c3a7);
    rd(`ADDR_STATUS, 32'h9);
    ext_feature_en_n <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(`ADDR_STATUS, 32'h1);
    ext_feature_en_n <= 1'b0;
    pll_ctrl_model_inst.pulse(4);
    rd(`ADDR_SECONDARY, 32'h5c3a7);
  endtask
  task t_dir;
    mode(1'b0, 1'b1);
    direct_ref <= 4'h3;
    direct_swallow <= 4'h9;
    pll_ctrl_model_inst.drive(8'h85);
    pll_ctrl_model_inst.pulse(5);
    rd(`ADDR_ACTIVE, 32'h81439);
    rd(`ADDR_SECONDARY, 32'h5c3a7);
  endtask
  // Ratio-one dividers: a reference edge raises, a main edge clears, a second main edge lowers.
  task t_pfd;
    direct_ref <= 4'h0;
    pll_ctrl_model_inst.drive(8'h80);
    reference_input <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(pfd_word, 32'hc1);
    @(posedge mclk);
    chk(pfd_word, 32'h70);
    vco_input <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(pfd_word, 32'h76);
    @(posedge mclk);
    chk(pfd_word, 32'hc4);
    vco_input <= 1'b0;
    repeat (4) @(posedge mclk);
    vco_input <= 1'b1;
    repeat (7) @(posedge mclk);
    chk(pfd_word, 32'hb4);
  endtask
  task t_bus;
    wr(`ADDR_CTRL, 32'h1, `RESP_OKAY);
    rd(`ADDR_CTRL, 32'h1);
    wr(`ADDR_PRIMARY, 32'h0, `RESP_SLVERR);
    wr(32'h40, 32'h0, `RESP_SLVERR);
    rd(32'h40, 32'h0, `RESP_SLVERR);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    t_par();
    t_ser();
    t_dir();
    t_pfd();
    t_bus();
    summarize();
  end
endmodule

// File: dv/pll_ctrl_model.sv
// Controller model that drives the program pins of the counter port.
`timescale 1ns/1ns
module pll_ctrl_model (
  input  wire logic       mclk,
  output logic      [7:0] par_data,
  output logic            serial_clk,
  output logic            serial_data,
  output wire logic       swallow_write_strobe,
  output wire logic       main_low_write_strobe,
  output wire logic       high_nibble_write_strobe,
  output wire logic       enh_write_strobe,
  output wire logic       serial_load_strobe,
  output wire logic       bank_transfer_strobe
);
  logic [5:0] stb = 6'h00;
  // Strobe index: 0 swallow, 1 main low, 2 high nibble, 3 enhancement, 4 serial load, 5 bank transfer.
  assign {bank_transfer_strobe, serial_load_strobe, enh_write_strobe, high_nibble_write_strobe,
          main_low_write_strobe, swallow_write_strobe} = stb;
  initial begin
    par_data = 8'h00;
    serial_clk = 1'b0;
    serial_data = 1'b0;
  end
  // Holds a strobe 80 ns high and 80 ns low, well over the pin synchroniser delay.
  task pulse(input int i);
    stb[i] <= 1'b1;
    repeat (8) @(posedge mclk);
    stb[i] <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
  // Byte write; the bus falls back to its pull-down level once the strobe is over.
  task par(input int i, input logic [7:0] d);
    par_data <= d;
    repeat (4) @(posedge mclk);
    pulse(i);
    par_data <= 8'h00;
    @(posedge mclk);
  endtask
  // Sets the data bus as a level, for direct mode.
  task drive(input logic [7:0] d);
    par_data <= d;
  endtask
  // Shifts n bits at a 160 ns clock that rests low between frames; e selects the enhancement target.
  task shift(input logic [19:0] v, input int n, input logic e);
    stb[3] <= e;
    for (int k = n - 1; k >= 0; k--) begin
      serial_data <= v[k];
      repeat (4) @(posedge mclk);
      serial_clk <= 1'b1;
      repeat (8) @(posedge mclk);
      serial_clk <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    serial_data <= 1'b0;
    stb[3] <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
endmodule

// File: rtl/pll_counter_program_port.sv
// Counter program port, dividers and phase comparator of the synthesizer.
`timescale 1ns/1ns
`include "pll_params.svh"
module pll_counter_program_port (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [7:0]  par_data,
  input  wire logic [3:0]  direct_ref,
  input  wire logic [3:0]  direct_swallow,
  input  wire logic        serial_clk,
  input  wire logic        serial_data,
  input  wire logic        enh_write_strobe,
  input  wire logic        serial_load_strobe,
  input  wire logic        bank_transfer_strobe,
  input  wire logic        high_nibble_write_strobe,
  input  wire logic        main_low_write_strobe,
  input  wire logic        swallow_write_strobe,
  input  wire logic        parallel_bank_select,
  input  wire logic        serial_bank_select,
  input  wire logic        serial_sel,
  input  wire logic        direct_sel,
  input  wire logic        ext_feature_en_n,
  input  wire logic        reference_input,
  input  wire logic        vco_input,
  output logic             phase_pulse_lower_n,
  output logic             phase_pulse_raise_n,
  output logic             lock_filter_node,
  output logic             lock_indicator_out,
  output logic             lock_indicator_oe,
  output logic             main_divider_monitor,
  output logic             reference_divider_monitor,
  output logic             diag_out
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Chooses the loading mode from the two mode pins.
  function automatic pll_pkg::mode_t decode_mode(input logic dsel, input logic ssel);
    if (dsel) begin
      return pll_pkg::MODE_DIRECT;
    end
    return ssel ? pll_pkg::MODE_SERIAL : pll_pkg::MODE_PARALLEL;
  endfunction

  // Maps a bus address onto a register, or none when unmapped.
  function automatic pll_pkg::reg_sel_t decode_addr(input logic [31:0] a);
    if (a[31:8] != 24'h000000) begin
      return pll_pkg::REG_NONE;
    end
    case (a[7:0])
      `ADDR_CTRL:      return pll_pkg::REG_CTRL;
      `ADDR_PRIMARY:   return pll_pkg::REG_PRIMARY;
      `ADDR_SECONDARY: return pll_pkg::REG_SECONDARY;
      `ADDR_ENH:       return pll_pkg::REG_ENH;
      `ADDR_STATUS:    return pll_pkg::REG_STATUS;
      `ADDR_ACTIVE:    return pll_pkg::REG_ACTIVE;
      default:         return pll_pkg::REG_NONE;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  pll_pkg::pin_sample_t pins_raw;
  pll_pkg::pin_sample_t s1_reg;
  pll_pkg::pin_sample_t s2_reg;
  pll_pkg::pin_sample_t s3_reg;
  pll_pkg::pin_sample_t rise;
  pll_pkg::mode_t       mode;

  // Gathers all pins into one sample word.
  assign pins_raw = {par_data, direct_ref, direct_swallow, serial_clk, serial_data,
                     enh_write_strobe, serial_load_strobe, bank_transfer_strobe,
                     high_nibble_write_strobe, main_low_write_strobe, swallow_write_strobe,
                     parallel_bank_select, serial_bank_select, serial_sel, direct_sel,
                     ext_feature_en_n, reference_input, vco_input};

  // Two flip-flops per pin, then a third stage for edge finding.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pins_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Rising edges and the current loading mode.
  assign rise = s2_reg & ~s3_reg;
  assign mode = decode_mode(s2_reg.direct_sel, s2_reg.serial_sel);

  // ---------------------------------------------------------------
  // Program registers
  // ---------------------------------------------------------------
  logic [`PRIM_W-1:0] primary_reg;
  logic [`PRIM_W-1:0] secondary_reg;
  logic [`ENH_W-1:0]  enh_reg;
  logic [`PRIM_W-1:0] active_word;
  logic [`ENH_W-1:0]  enh_eff;
  logic               ser_mode;
  logic               par_mode;

  assign ser_mode = (mode == pll_pkg::MODE_SERIAL);
  assign par_mode = (mode == pll_pkg::MODE_PARALLEL);

  // Primary register: serial shift, MSB first, or parallel field writes.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      primary_reg <= `PRIM_RESET;
    end else if (ser_mode) begin
      if (rise.serial_clk && !s2_reg.enh_write_strobe) begin
        primary_reg <= {primary_reg[`PRIM_W-2:0], s2_reg.serial_data};
      end
    end else if (par_mode) begin
      if (rise.high_nibble_write_strobe) begin
        primary_reg[`PRIM_REF_MSB -: 2]  <= s2_reg.par_data[3:2];
        primary_reg[`PRIM_MAIN_MSB -: 2] <= s2_reg.par_data[1:0];
      end
      if (rise.main_low_write_strobe) begin
        primary_reg[`PRIM_PRE_BIT -: 1]       <= s2_reg.par_data[7 -: 1];
        primary_reg[`PRIM_MAIN_LSB +: 7]      <= s2_reg.par_data[6:0];
      end
      if (rise.swallow_write_strobe) begin
        primary_reg[`PRIM_REF_LSB +: 4]  <= s2_reg.par_data[7:4];
        primary_reg[`PRIM_SWAL_MSB:`PRIM_SWAL_LSB] <= s2_reg.par_data[3:0];
      end
    end
  end

  // Secondary register copies the whole primary word on a transfer strobe.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      secondary_reg <= `PRIM_RESET;
    end else if ((ser_mode || par_mode) && rise.bank_transfer_strobe) begin
      secondary_reg <= primary_reg;
    end else if (ser_mode && rise.serial_load_strobe) begin
      secondary_reg <= primary_reg;
    end
  end

  // Enhancement register: serial shift or parallel byte capture.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      enh_reg <= `ENH_RESET;
    end else if (ser_mode && rise.serial_clk && s2_reg.enh_write_strobe) begin
      enh_reg <= {enh_reg[`ENH_W-2:0], s2_reg.serial_data};
    end else if (par_mode && rise.enh_write_strobe) begin
      enh_reg <= s2_reg.par_data;
    end
  end

  // Enhancement bits count only with the enable pin low, outside direct mode.
  assign enh_eff = (!s2_reg.ext_feature_en_n && !s2_reg.direct_sel) ? enh_reg : `ENH_RESET;

  // Word that programs the counters, per mode and bank select.
  always_comb begin
    case (mode)
      pll_pkg::MODE_DIRECT:
        active_word = {s2_reg.par_data[7], 2'b00, s2_reg.par_data[6:0], 2'b00,
                       s2_reg.direct_ref, s2_reg.direct_swallow};
      pll_pkg::MODE_SERIAL:
        active_word = s2_reg.serial_bank_select ? primary_reg : secondary_reg;
      pll_pkg::MODE_PARALLEL:
        active_word = s2_reg.parallel_bank_select ? primary_reg : secondary_reg;
      default:
        active_word = secondary_reg;
    endcase
  end

  // ---------------------------------------------------------------
  // Dividers
  // ---------------------------------------------------------------
  logic [5:0] ref_cnt_reg;
  logic       ref_pulse_reg;
  logic [3:0] presc_cnt_reg;
  logic       presc_pulse_reg;
  logic [8:0] main_cnt_reg;
  logic [3:0] swal_cnt_reg;
  logic       main_pulse_reg;
  logic       modulus_control;
  logic       presc_bypass;

  assign modulus_control = (swal_cnt_reg != 4'h0);
  assign presc_bypass    = active_word[`PRIM_PRE_BIT];

  // Reference divider counts reference edges, ratio ref count plus one.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_cnt_reg   <= 6'h00;
      ref_pulse_reg <= 1'b0;
    end else begin
      ref_pulse_reg <= 1'b0;
      if (rise.reference_input) begin
        if (ref_cnt_reg == 6'h00) begin
          ref_cnt_reg   <= active_word[`PRIM_REF_MSB:`PRIM_REF_LSB];
          ref_pulse_reg <= 1'b1;
        end else begin
          ref_cnt_reg <= ref_cnt_reg - 6'h01;
        end
      end
    end
  end

  // Dual-modulus prescaler, divide by 10 or 11, or bypassed.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_cnt_reg   <= 4'h0;
      presc_pulse_reg <= 1'b0;
    end else begin
      presc_pulse_reg <= 1'b0;
      if (rise.vco_input) begin
        if (presc_bypass) begin
          presc_pulse_reg <= 1'b1;
        end else if (presc_cnt_reg == 4'h0) begin
          presc_cnt_reg   <= modulus_control ? `PRESC_RELOAD_11 : `PRESC_RELOAD_10;
          presc_pulse_reg <= 1'b1;
        end else begin
          presc_cnt_reg <= presc_cnt_reg - 4'h1;
        end
      end
    end
  end

  // Main and swallow counters clocked by the prescaler output.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      main_cnt_reg   <= 9'h000;
      swal_cnt_reg   <= 4'h0;
      main_pulse_reg <= 1'b0;
    end else begin
      main_pulse_reg <= 1'b0;
      if (presc_pulse_reg) begin
        if (main_cnt_reg == 9'h000) begin
          main_cnt_reg   <= active_word[`PRIM_MAIN_MSB:`PRIM_MAIN_LSB];
          swal_cnt_reg   <= active_word[`PRIM_SWAL_MSB:`PRIM_SWAL_LSB];
          main_pulse_reg <= 1'b1;
        end else begin
          main_cnt_reg <= main_cnt_reg - 9'h001;
          if (modulus_control) begin
            swal_cnt_reg <= swal_cnt_reg - 4'h1;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Phase comparator, lock detect and monitor outputs
  // ---------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic        up_flag_reg;
  logic        down_flag_reg;
  logic        up_set;
  logic        down_set;

  assign up_set   = up_flag_reg | ref_pulse_reg;
  assign down_set = down_flag_reg | main_pulse_reg;

  // Flags set by divider pulses, both cleared once both are set.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      up_flag_reg   <= 1'b0;
      down_flag_reg <= 1'b0;
    end else if (ctrl_reg[`CTRL_PFD_HOLD_BIT] || (up_set && down_set)) begin
      up_flag_reg   <= 1'b0;
      down_flag_reg <= 1'b0;
    end else begin
      up_flag_reg   <= up_set;
      down_flag_reg <= down_set;
    end
  end

  // Registered pin outputs.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_pulse_raise_n       <= 1'b1;
      phase_pulse_lower_n       <= 1'b1;
      lock_filter_node          <= 1'b0;
      lock_indicator_oe         <= 1'b0;
      main_divider_monitor      <= 1'b0;
      reference_divider_monitor <= 1'b0;
      diag_out                  <= 1'b0;
    end else begin
      phase_pulse_raise_n       <= ~up_flag_reg;
      phase_pulse_lower_n       <= ~down_flag_reg;
      lock_filter_node          <= up_flag_reg | down_flag_reg;
      lock_indicator_oe         <= up_flag_reg | down_flag_reg;
      main_divider_monitor      <= main_pulse_reg & ~enh_eff[`ENH_MAIN_OFF_BIT];
      reference_divider_monitor <= ref_pulse_reg & ~enh_eff[`ENH_REF_OFF_BIT];
      diag_out <= enh_eff[`ENH_DIAG_BIT] ? presc_pulse_reg : modulus_control;
    end
  end

  // The open-drain indicator only ever pulls low.
  assign lock_indicator_out = 1'b0;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic               aw_got_reg;
  logic               w_got_reg;
  logic [31:0]        aw_addr_reg;
  logic [31:0]        w_data_reg;
  logic [3:0]         w_strb_reg;
  pll_pkg::reg_sel_t  wsel;
  pll_pkg::reg_sel_t  rsel;
  logic [31:0]        rword;

  assign awready = !aw_got_reg && !bvalid;
  assign wready  = !w_got_reg && !bvalid;
  assign arready = !rvalid;
  assign wsel    = decode_addr(aw_addr_reg);
  assign rsel    = decode_addr(araddr);

  // Write side: address and data taken in any order, answered together.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      aw_addr_reg <= 32'h00000000;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid      <= 1'b0;
      bresp       <= `RESP_OKAY;
      ctrl_reg    <= `CTRL_RESET;
    end else begin
      if (awvalid && awready) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (aw_got_reg && w_got_reg) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= (wsel == pll_pkg::REG_CTRL) ? `RESP_OKAY : `RESP_SLVERR;
        if (wsel == pll_pkg::REG_CTRL) begin
          for (int i = 0; i < 4; i++) begin
            if (w_strb_reg[i]) begin
              ctrl_reg[i*8 +: 8] <= w_data_reg[i*8 +: 8];
            end
          end
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read multiplexer.
  always_comb begin
    case (rsel)
      pll_pkg::REG_CTRL:      rword = ctrl_reg;
      pll_pkg::REG_PRIMARY:   rword = {12'h000, primary_reg};
      pll_pkg::REG_SECONDARY: rword = {12'h000, secondary_reg};
      pll_pkg::REG_ENH:       rword = {24'h000000, enh_reg};
      pll_pkg::REG_STATUS:    rword = {28'h0000000, (enh_eff != `ENH_RESET), lock_filter_node, mode};
      pll_pkg::REG_ACTIVE:    rword = {12'h000, active_word};
      default:                rword = 32'h00000000;
    endcase
  end

  // Read side: one-cycle answer held until taken.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rword;
      rresp  <= (rsel == pll_pkg::REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence main_leads;
    main_pulse_reg && !ref_pulse_reg && !up_flag_reg && !down_flag_reg && !ctrl_reg[`CTRL_PFD_HOLD_BIT];
  endsequence

  sequence ref_leads;
    ref_pulse_reg && !main_pulse_reg && !up_flag_reg && !down_flag_reg && !ctrl_reg[`CTRL_PFD_HOLD_BIT];
  endsequence

  a_par_bank_sel: assert property (par_mode |-> active_word == (s2_reg.parallel_bank_select ? primary_reg : secondary_reg))
    else $error("parallel bank select picks wrong word");
  a_enh_shift: assert property (ser_mode && rise.serial_clk && s2_reg.enh_write_strobe |=> enh_reg == {$past(enh_reg[6:0]), $past(s2_reg.serial_data)})
    else $error("enhancement serial shift wrong");
  a_enh_capture: assert property (par_mode && rise.enh_write_strobe |=> enh_reg == $past(s2_reg.par_data))
    else $error("enhancement byte not captured");
  a_nibble_write: assert property (par_mode && rise.high_nibble_write_strobe |=> primary_reg[9:8] == $past(s2_reg.par_data[3:2]) && primary_reg[18:17] == $past(s2_reg.par_data[1:0]))
    else $error("high nibble write wrong");
  a_main_low: assert property (par_mode && rise.main_low_write_strobe |=> primary_reg[19:10] == {$past(s2_reg.par_data[7]), primary_reg[18:17], $past(s2_reg.par_data[6:0])})
    else $error("main low write wrong");
  a_swallow_write: assert property (par_mode && rise.swallow_write_strobe |=> primary_reg[7:0] == $past(s2_reg.par_data))
    else $error("swallow write wrong");
  a_bank_copy: assert property ((par_mode || ser_mode) && rise.bank_transfer_strobe |=> secondary_reg == $past(primary_reg))
    else $error("bank transfer did not copy primary");
  a_serial_load: assert property (ser_mode && rise.serial_load_strobe |=> secondary_reg == $past(primary_reg))
    else $error("serial load did not copy primary");
  a_prim_shift: assert property (ser_mode && rise.serial_clk && !s2_reg.enh_write_strobe |=> primary_reg == {$past(primary_reg[18:0]), $past(s2_reg.serial_data)})
    else $error("primary serial shift wrong");
  a_direct_swal: assert property (s2_reg.direct_sel |-> active_word[3:0] == s2_reg.direct_swallow)
    else $error("direct swallow count not from pins");
  a_cext_nand: assert property (lock_filter_node == !(phase_pulse_raise_n && phase_pulse_lower_n))
    else $error("lock filter node not NAND of pulses");
  a_lower_pulse: assert property (main_leads |-> ##2 !phase_pulse_lower_n && phase_pulse_raise_n)
    else $error("lower pulse missing when main leads");
  a_raise_pulse: assert property (ref_leads |-> ##2 !phase_pulse_raise_n && phase_pulse_lower_n)
    else $error("raise pulse missing when reference leads");
  a_lock_drive: assert property (lock_indicator_oe == lock_filter_node && !lock_indicator_out)
    else $error("lock indicator not inverse of filter node");
  a_enh_gate: assert property (s2_reg.ext_feature_en_n |=> !main_divider_monitor || $past(main_pulse_reg))
    else $error("monitor active without divider pulse");
  a_mon_suppress: assert property (main_pulse_reg && enh_eff[`ENH_MAIN_OFF_BIT] |=> !main_divider_monitor)
    else $error("main monitor not suppressed");
endmodule

// File: rtl/pll_params.svh
// Constants for the synthesizer counter program port.
// Behaviour
// - Parallel mode: bank select 1 primary, 0 secondary.
// - Serial, enhancement strobe high: shift into enhancement.
// - Parallel enhancement strobe captures data byte.
// - High nibble strobe stores ref[5:4], main[8:7].
// - Serial select 1 serial, 0 parallel.
// - Direct select 1 takes counts from pins.
// - Main low strobe stores prescaler enable, main[6:0].
// - Swallow strobe stores ref[3:0], swallow[3:0].
// - Bank transfer strobe copies primary to secondary.
// - Direct swallow count from four pins, bit0 LSB.
// - Lock filter node is NAND of pulses.
// - Lower pulse low when main leads reference.
// - Raise pulse low when reference leads main.
// - Lock indicator released when locked, else low.
// - Enhancement bits act only with enable low.
// - Diagnostic output shows modulus control or prescaler.
// - Main monitor shows main divider, suppressible.
// - Reference monitor shows reference divider, suppressible.
// - Enhancement strobe low: shift into 20-bit primary.
// - Serial load or transfer strobe copies primary.
// - Prescaler enable active low; high bypasses prescaler.
`ifndef PLL_PARAMS_SVH
`define PLL_PARAMS_SVH
// ---------------------------------------------------------------
// Program word layout
// ---------------------------------------------------------------
`define PRIM_W 20
`define ENH_W 8
`define PRIM_RESET 20'h00000
`define ENH_RESET 8'h00
`define PRIM_PRE_BIT 19
`define PRIM_MAIN_MSB 18
`define PRIM_MAIN_LSB 10
`define PRIM_REF_MSB 9
`define PRIM_REF_LSB 4
`define PRIM_SWAL_MSB 3
`define PRIM_SWAL_LSB 0
`define ENH_DIAG_BIT 0
`define ENH_MAIN_OFF_BIT 1
`define ENH_REF_OFF_BIT 2
`define PRESC_RELOAD_10 4'h9
`define PRESC_RELOAD_11 4'ha
// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_PRIMARY 8'h04
`define ADDR_SECONDARY 8'h08
`define ADDR_ENH 8'h0c
`define ADDR_STATUS 8'h10
`define ADDR_ACTIVE 8'h14
`define CTRL_PFD_HOLD_BIT 0
`define CTRL_RESET 32'h00000000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// File: rtl/pll_pkg.sv
// Types shared by the synthesizer counter program port.
package pll_pkg;
  typedef enum logic [1:0] {
    MODE_PARALLEL = 2'b00,
    MODE_SERIAL   = 2'b01,
    MODE_DIRECT   = 2'b10
  } mode_t;

  typedef enum logic [2:0] {
    REG_CTRL      = 3'b000,
    REG_PRIMARY   = 3'b001,
    REG_SECONDARY = 3'b010,
    REG_ENH       = 3'b011,
    REG_STATUS    = 3'b100,
    REG_ACTIVE    = 3'b101,
    REG_NONE      = 3'b111
  } reg_sel_t;

  typedef struct packed {
    logic [7:0] par_data;
    logic [3:0] direct_ref;
    logic [3:0] direct_swallow;
    logic       serial_clk;
    logic       serial_data;
    logic       enh_write_strobe;
    logic       serial_load_strobe;
    logic       bank_transfer_strobe;
    logic       high_nibble_write_strobe;
    logic       main_low_write_strobe;
    logic       swallow_write_strobe;
    logic       parallel_bank_select;
    logic       serial_bank_select;
    logic       serial_sel;
    logic       direct_sel;
    logic       ext_feature_en_n;
    logic       reference_input;
    logic       vco_input;
  } pin_sample_t;
endpackage
